/* File: logic/pao_top.sv */
// Phase accumulator oscillator with AXI4-Lite register slave.
//
// Contract
// R1: twenty-bit accumulator; carry is raw output.
// R2: each input clock edge adds buffered increment.
// R3: overflow event on every adder carry out.
// R4: six selectable accumulator clock sources.
// R5: source codes 000 sys, 001 hf, 010-101 cells.
// R6: accumulator readable, writable as three bytes.
// R7: increment stored as low, high, upper bytes.
// R8: software writes upper, high, then low byte.
// R9: enabled: buffer loads second edge after low write.
// R10: increment double-buffered, buffer hidden.
// R11: disabled: buffer loads right after any write.
// R12: fixed duty mode toggles on each overflow.
// R13: mode bit one pulse, zero fixed duty.
// R14: pulse active next edge, held, then inactive.
// R15: pulse width is two to select periods.
// R16: software keeps pulse shorter than overflow period.
// R17: polarity bit inverts output as last stage.
// R18: polarity change raises interrupt when enabled.
// R19: output goes to peripherals and pin.
// R20: each overflow sets the interrupt flag.
// R21: request needs enable, ie, peripheral_irq_enable, gie set.
// R22: flag stays set until software clears it.
// R23: reset clears every register to zero.
// R24: keeps running from selected clock in sleep.
// R25: enabled with hf source keeps oscillator on.
// R26: read-only status bit shows output level.
// R27: enable bit one enables, zero disables.
// R28: software avoids accumulator writes while running.
// R29: flag and status synchronised before software reads.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module pao_top #(
    parameter int ACC_W = pao_pkg::ACC_W
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic internal_hf_oscillator,
    input wire logic logic_cell_one_output,
    input wire logic logic_cell_two_output,
    input wire logic logic_cell_three_output,
    input wire logic logic_cell_four_output,
    output logic synth_output,
    output logic synth_pin_out,
    output logic synth_pin_oe,
    input wire logic synth_pin_route,
    output logic hf_osc_keep_on,
    output logic irq_request
);
    // Write address and data are latched independently and joined later.
    logic aw_full_q;
    logic w_full_q;
    pao_pkg::pao_wreq_t wreq_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    logic [7:0] control_q;
    logic [7:0] clk_cfg_q;
    logic [7:0] irq_q;
    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] inc_q;
    logic [ACC_W-1:0] incbuf_q;
    pao_pkg::pao_ld_t ld_q;
    logic fdc_q;
    logic [7:0] pulse_cnt_q;
    logic pulse_q;
    logic out_q;
    logic out_prev_q;
    logic clk_s_q;
    logic clk_prev_q;

    wire module_en = control_q[pao_pkg::CON_EN]; // [R27]
    wire pulse_mode = control_q[pao_pkg::CON_PFM];
    wire invert = control_q[pao_pkg::CON_POL];
    wire [2:0] pws = clk_cfg_q[pao_pkg::PWS_LSB +: 3];
    wire [2:0] cks = clk_cfg_q[pao_pkg::CKS_LSB +: 3];

    // The source mux output is sampled once, then edge detected.  The system
    // clock source is represented by a tick on every second bus clock.
    logic src_level;
    always_comb
    begin
        unique case (pao_pkg::pao_src_t'(cks)) // [R4] [R5]
            pao_pkg::PAO_SRC_SYS: src_level = ~clk_s_q;
            pao_pkg::PAO_SRC_HFOSC: src_level = internal_hf_oscillator;
            pao_pkg::PAO_SRC_LC1: src_level = logic_cell_one_output;
            pao_pkg::PAO_SRC_LC2: src_level = logic_cell_two_output;
            pao_pkg::PAO_SRC_LC3: src_level = logic_cell_three_output;
            pao_pkg::PAO_SRC_LC4: src_level = logic_cell_four_output;
            default: src_level = 1'b0;
        endcase
    end

    wire src_rise = clk_s_q & ~clk_prev_q;
    wire tick = module_en & src_rise; // [R24]
    assign hf_osc_keep_on = module_en &&
        cks == 3'(pao_pkg::PAO_SRC_HFOSC); // [R25]

    wire [ACC_W:0] sum = {1'b0, acc_q} + {1'b0, incbuf_q}; // [R1]
    wire carry = tick & sum[ACC_W]; // [R3]

    function automatic logic [7:0] width_of(input logic [2:0] sel);
        width_of = 8'(9'h001 << sel); // [R15]
    endfunction

    // Bus decode.
    wire do_write = aw_full_q & w_full_q & ~bvalid_q;
    wire [5:0] waddr = wreq_q.addr;
    wire [7:0] wbyte = wreq_q.strb[0] ? wreq_q.data[7:0] : pao_pkg::BYTE_ZERO;
    wire wen = do_write & wreq_q.strb[0];
    wire wr_ctl = wen && waddr == pao_pkg::OFF_CONTROL;
    wire wr_cfg = wen && waddr == pao_pkg::OFF_CLK_CFG;
    wire wr_al = wen && waddr == pao_pkg::OFF_ACC_L;
    wire wr_ah = wen && waddr == pao_pkg::OFF_ACC_H;
    wire wr_au = wen && waddr == pao_pkg::OFF_ACC_U;
    wire wr_il = wen && waddr == pao_pkg::OFF_INC_L;
    wire wr_ih = wen && waddr == pao_pkg::OFF_INC_H;
    wire wr_iu = wen && waddr == pao_pkg::OFF_INC_U;
    wire wr_irq = wen && waddr == pao_pkg::OFF_IRQ;
    wire wr_inc = wr_il | wr_ih | wr_iu;

    function automatic logic mapped(input logic [5:0] a);
        mapped = a <= pao_pkg::OFF_IRQ && a[1:0] == 2'b00;
    endfunction

    // Output stage: pulse or toggled level, then polarity.
    wire raw_level = pulse_mode ? pulse_q : fdc_q; // [R13]
    wire out_d = raw_level ^ invert; // [R17]
    wire pol_irq = wr_ctl && out_d != ((wbyte[pao_pkg::CON_POL]) ^ raw_level)
        && irq_q[pao_pkg::IRQ_IE]; // [R18]
    wire flag_set = carry | pol_irq;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clk_s_q <= 1'b0;
            clk_prev_q <= 1'b0;
        end
        else
        begin
            clk_s_q <= src_level;
            clk_prev_q <= clk_s_q;
        end
    end

    // Accumulator, double-buffered increment and its load sequencer.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            acc_q <= '0; // [R23]
            inc_q <= '0;
            incbuf_q <= '0;
            ld_q <= pao_pkg::PAO_LD_IDLE;
        end
        else
        begin
            if (wr_al)
                acc_q[7:0] <= wbyte; // [R6] [R28]
            else if (wr_ah)
                acc_q[15:8] <= wbyte;
            else if (wr_au)
                acc_q[19:16] <= wbyte[3:0];
            else if (tick)
                acc_q <= sum[ACC_W-1:0]; // [R2]
            if (wr_il)
                inc_q[7:0] <= wbyte; // [R7] [R8]
            if (wr_ih)
                inc_q[15:8] <= wbyte;
            if (wr_iu)
                inc_q[19:16] <= wbyte[3:0];
            if (!module_en)
            begin
                if (!wr_inc)
                    incbuf_q <= inc_q; // [R11] [R10]
                ld_q <= pao_pkg::PAO_LD_IDLE;
            end
            else if (wr_il)
                ld_q <= pao_pkg::PAO_LD_WAIT1;
            else
            begin
                unique case (ld_q)
                    pao_pkg::PAO_LD_IDLE: ld_q <= pao_pkg::PAO_LD_IDLE;
                    pao_pkg::PAO_LD_WAIT1:
                        if (src_rise)
                            ld_q <= pao_pkg::PAO_LD_WAIT2;
                    pao_pkg::PAO_LD_WAIT2:
                        if (src_rise)
                        begin
                            incbuf_q <= inc_q; // [R9]
                            ld_q <= pao_pkg::PAO_LD_IDLE;
                        end
                    default: ld_q <= pao_pkg::PAO_LD_IDLE;
                endcase
            end
        end
    end

    // Output generators.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fdc_q <= 1'b0;
            pulse_q <= 1'b0;
            pulse_cnt_q <= pao_pkg::BYTE_ZERO;
            out_q <= 1'b0;
            out_prev_q <= 1'b0;
        end
        else
        begin
            if (carry)
                fdc_q <= ~fdc_q; // [R12]
            if (carry)
            begin
                pulse_q <= 1'b1; // [R14] [R16]
                pulse_cnt_q <= width_of(pws);
            end
            else if (tick && pulse_cnt_q != pao_pkg::BYTE_ZERO)
            begin
                pulse_cnt_q <= pulse_cnt_q - 8'h01;
                if (pulse_cnt_q == 8'h01)
                    pulse_q <= 1'b0;
            end
            out_q <= out_d;
            out_prev_q <= out_q;
        end
    end

    assign synth_output = out_q; // [R19]
    assign synth_pin_out = out_q;
    assign synth_pin_oe = synth_pin_route;

    // Register writes, sticky flag with set beating clear.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            control_q <= pao_pkg::BYTE_ZERO;
            clk_cfg_q <= pao_pkg::BYTE_ZERO;
            irq_q <= pao_pkg::BYTE_ZERO;
        end
        else
        begin
            if (wr_ctl)
                control_q <= wbyte & pao_pkg::CON_WMASK;
            if (wr_cfg)
                clk_cfg_q <= wbyte & pao_pkg::CLK_WMASK;
            if (wr_irq)
                irq_q <= wbyte & pao_pkg::IRQ_WMASK;
            if (flag_set)
                irq_q[pao_pkg::IRQ_FLAG] <= 1'b1; // [R20] [R22]
        end
    end

    assign irq_request = module_en & irq_q[pao_pkg::IRQ_FLAG] &
        irq_q[pao_pkg::IRQ_IE] & irq_q[pao_pkg::IRQ_PERIPHERAL_IRQ_ENABLE] &
        irq_q[pao_pkg::IRQ_GIE]; // [R21]

    // Flag and output live in the bus domain already, so a read sees them
    // with no further crossing; out_q is the registered level.
    logic [7:0] rbyte;
    wire [5:0] raddr = s_axi_araddr;
    always_comb
    begin
        rbyte = pao_pkg::BYTE_ZERO;
        unique case (raddr)
            pao_pkg::OFF_CONTROL:
            begin
                rbyte = control_q;
                rbyte[pao_pkg::CON_OUT] = out_q; // [R26] [R29]
            end
            pao_pkg::OFF_CLK_CFG: rbyte = clk_cfg_q;
            pao_pkg::OFF_ACC_L: rbyte = acc_q[7:0];
            pao_pkg::OFF_ACC_H: rbyte = acc_q[15:8];
            pao_pkg::OFF_ACC_U: rbyte = {4'h0, acc_q[19:16]};
            pao_pkg::OFF_INC_L: rbyte = inc_q[7:0];
            pao_pkg::OFF_INC_H: rbyte = inc_q[15:8];
            pao_pkg::OFF_INC_U: rbyte = {4'h0, inc_q[19:16]};
            pao_pkg::OFF_IRQ: rbyte = irq_q;
            default: rbyte = pao_pkg::BYTE_ZERO;
        endcase
    end

    // AXI4-Lite handshakes.
    assign s_axi_awready = ~aw_full_q;
    assign s_axi_wready = ~w_full_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            wreq_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= pao_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= pao_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && !aw_full_q)
            begin
                aw_full_q <= 1'b1;
                wreq_q.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full_q)
            begin
                w_full_q <= 1'b1;
                wreq_q.data <= s_axi_wdata;
                wreq_q.strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= mapped(waddr) ? pao_pkg::RESP_OKAY
                                         : pao_pkg::RESP_SLVERR;
            end
            if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
            end
            if (s_axi_arvalid && !rvalid_q)
            begin
                rvalid_q <= 1'b1;
                rdata_q <= {24'h000000, rbyte};
                rresp_q <= mapped(raddr) ? pao_pkg::RESP_OKAY
                                         : pao_pkg::RESP_SLVERR;
            end
            else if (rvalid_q && s_axi_rready)
                rvalid_q <= 1'b0;
        end
    end

    // Checks.
    a_acc_adds: assert property (@(posedge aclk) disable iff (!aresetn)
        tick && !(wr_al || wr_ah || wr_au) |=>
        acc_q == $past(sum[ACC_W-1:0]))
        else $error("accumulator did not add increment"); // [R2]
    a_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        carry |=> irq_q[pao_pkg::IRQ_FLAG])
        else $error("overflow did not set flag"); // [R20]
    a_fdc_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
        carry |=> fdc_q != $past(fdc_q))
        else $error("fixed duty level did not toggle"); // [R12]
    a_pulse_start: assert property (@(posedge aclk) disable iff (!aresetn)
        carry |=> pulse_q && pulse_cnt_q == width_of($past(pws)))
        else $error("pulse did not start with width"); // [R14]
    a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_request |-> module_en && irq_q[pao_pkg::IRQ_GIE])
        else $error("interrupt raised while gated"); // [R21]
    a_flag_holds: assert property (@(posedge aclk) disable iff (!aresetn)
        irq_q[pao_pkg::IRQ_FLAG] && !wr_irq |=> irq_q[pao_pkg::IRQ_FLAG])
        else $error("flag dropped without a clear"); // [R22]
    a_disabled_load: assert property (@(posedge aclk) disable iff (!aresetn)
        !module_en && !wr_inc ##1 !module_en |-> incbuf_q == $past(inc_q))
        else $error("buffer not loaded while disabled"); // [R11]
    a_out_polarity: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> out_q == ($past(raw_level) ^ $past(invert)))
        else $error("output polarity wrong"); // [R17]
endmodule

/* File: logic/pao_pkg.sv */
// Package for the phase accumulator oscillator: register map and fields.
package pao_pkg;
    localparam int ACC_W = 20;
    localparam int ADDR_W = 6;
    // Byte addresses of the word-aligned registers.
    localparam logic [5:0] OFF_CONTROL = 6'h00;
    localparam logic [5:0] OFF_CLK_CFG = 6'h04;
    localparam logic [5:0] OFF_ACC_L = 6'h08;
    localparam logic [5:0] OFF_ACC_H = 6'h0C;
    localparam logic [5:0] OFF_ACC_U = 6'h10;
    localparam logic [5:0] OFF_INC_L = 6'h14;
    localparam logic [5:0] OFF_INC_H = 6'h18;
    localparam logic [5:0] OFF_INC_U = 6'h1C;
    localparam logic [5:0] OFF_IRQ = 6'h20;
    // Control register fields.
    localparam int CON_EN = 7;
    localparam int CON_OUT = 5;
    localparam int CON_POL = 4;
    localparam int CON_PFM = 0;
    // Interrupt register fields.
    localparam int IRQ_FLAG = 0;
    localparam int IRQ_IE = 1;
    localparam int IRQ_PERIPHERAL_IRQ_ENABLE = 2;
    localparam int IRQ_GIE = 3;
    // Clock configuration fields.
    localparam int PWS_LSB = 5;
    localparam int CKS_LSB = 0;
    localparam logic [7:0] CON_WMASK = 8'h91;
    localparam logic [7:0] CLK_WMASK = 8'hE7;
    localparam logic [7:0] UPPER_MASK = 8'h0F;
    localparam logic [7:0] IRQ_WMASK = 8'h0F;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [2:0]
    {
        PAO_SRC_SYS = 3'b000,
        PAO_SRC_HFOSC = 3'b001,
        PAO_SRC_LC1 = 3'b010,
        PAO_SRC_LC2 = 3'b011,
        PAO_SRC_LC3 = 3'b100,
        PAO_SRC_LC4 = 3'b101,
        PAO_SRC_RSV6 = 3'b110,
        PAO_SRC_RSV7 = 3'b111
    } pao_src_t;

    typedef enum logic [1:0]
    {
        PAO_LD_IDLE = 2'b00,
        PAO_LD_WAIT1 = 2'b01,
        PAO_LD_WAIT2 = 2'b10
    } pao_ld_t;

    typedef struct packed
    {
        logic [5:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } pao_wreq_t;
endpackage

/* File: verification/pao_consumer.sv */
// Model of an on-chip peripheral that consumes the synthesized output.
`timescale 1ns/1ps
module pao_consumer (
    input wire logic aclk,
    input wire logic clear,
    input wire logic synth_output,
    output int rise_count,
    output int high_cycles
);
    logic last_q;

    // An edge-triggered load counts rises, so glitch-free output matters.
    always_ff @(posedge aclk)
    begin
        last_q <= synth_output;
        if (clear)
        begin
            rise_count <= 0;
            high_cycles <= 0;
        end
        else
        begin
            if (synth_output && !last_q)
                rise_count <= rise_count + 1;
            if (synth_output)
                high_cycles <= high_cycles + 1;
        end
    end
endmodule

/* File: verification/testbench.sv */
// Self-checking bench for the phase accumulator oscillator.
`timescale 1ns/1ps
module testbench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [5:0] awaddr = 6'h00;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h00000000;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [5:0] araddr = 6'h00;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic [4:0] src = 5'h00;
    logic route = 1'b1;
    logic mon_clear = 1'b1;
    logic synth_output, pin_out, pin_oe, keep_on, irq_request;
    logic [31:0] rd;
    logic [1:0] resp;
    logic [7:0] r3;
    int err_count = 0;
    int checks_done = 0;

    initial
    begin
        forever #2 aclk = ~aclk;
    end

    pao_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .internal_hf_oscillator(src[0]),
        .logic_cell_one_output(src[1]), .logic_cell_two_output(src[2]),
        .logic_cell_three_output(src[3]), .logic_cell_four_output(src[4]),
        .synth_output(synth_output), .synth_pin_out(pin_out),
        .synth_pin_oe(pin_oe), .synth_pin_route(route),
        .hf_osc_keep_on(keep_on), .irq_request(irq_request));

    pao_consumer partner (.aclk(aclk), .clear(mon_clear),
        .synth_output(synth_output), .rise_count(), .high_cycles());

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Valid or ready is sampled at the falling edge: it only moves after rising
    // edges, so this equals its value at the next rising edge.
    task automatic await(input int which);
        logic hit;
        int n;
        n = 0;
        do
        begin
            @(negedge aclk);
            hit = (which == 0) ? bvalid : ((which == 1) ? arready : rvalid);
            rd = rdata;
            resp = (which == 0) ? bresp : rresp;
            @(posedge aclk);
            n++;
            if (n > 50)
            begin
                err_count++;
                $display("[FAIL] %0t handshake timed out", $time);
                print_verdict();
            end
        end while (hit !== 1'b1);
    endtask

    task automatic axi_write(input logic [5:0] a, input logic [7:0] d);
        logic aw_hit;
        logic w_hit;
        int n;
        n = 0;
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(negedge aclk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            @(posedge aclk);
            awvalid <= awvalid && !aw_hit;
            wvalid <= wvalid && !w_hit;
            n++;
            if (n > 50)
            begin
                err_count++;
                $display("[FAIL] %0t write address or data not taken", $time);
                print_verdict();
            end
        end while ((awvalid && !aw_hit) || (wvalid && !w_hit));
        bready <= 1'b1;
        await(0);
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [5:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        await(1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        await(2);
        rready <= 1'b0;
    endtask

    task automatic expect_reg(input logic [5:0] a, input logic [7:0] d);
        axi_read(a);
        check(rd, {24'h000000, d});
    endtask

    task automatic set_inc(input logic [7:0] u, h, l);
        axi_write(pao_pkg::OFF_INC_U, u);
        axi_write(pao_pkg::OFF_INC_H, h);
        axi_write(pao_pkg::OFF_INC_L, l);
    endtask

    // Source lines stand low between rises, as a gated clock would.
    task automatic pulse(input int idx, input int n);
        repeat (n)
        begin
            src[idx] <= 1'b1;
            repeat (4) @(posedge aclk);
            src[idx] <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask

    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int a = 0; a <= 32; a += 4)
            expect_reg(a[5:0], 8'h00);
        expect_reg(6'h24, 8'h00);
        check(resp, pao_pkg::RESP_SLVERR);
        axi_write(6'h02, 8'hFF);
        check(resp, pao_pkg::RESP_SLVERR);
        $display("test reset done");
        set_inc(8'h00, 8'h00, 8'h01);
        for (int c = 1; c <= 6; c++)
        begin
            axi_write(pao_pkg::OFF_CLK_CFG, 8'(c));
            axi_write(pao_pkg::OFF_CONTROL, 8'h80);
            check(keep_on, c == 1);
            pulse((c == 6) ? 1 : c - 1, 1);
            axi_write(pao_pkg::OFF_CONTROL, 8'h00);
            expect_reg(pao_pkg::OFF_ACC_L, 8'((c == 6) ? 5 : c));
        end
        // The system source ticks on every second bus clock, so an even
        // number of enabled edges gives a count that does not hang on phase.
        axi_write(pao_pkg::OFF_ACC_L, 8'h00);
        axi_write(pao_pkg::OFF_CLK_CFG, 8'h00);
        axi_write(pao_pkg::OFF_CONTROL, 8'h80);
        check(keep_on, 1'b0);
        repeat (7) @(posedge aclk);
        axi_write(pao_pkg::OFF_CONTROL, 8'h00);
        expect_reg(pao_pkg::OFF_ACC_L, 8'h05);
        $display("test sources done");
        axi_write(pao_pkg::OFF_ACC_L, 8'h00);
        set_inc(8'h04, 8'h00, 8'h01);
        axi_write(pao_pkg::OFF_CLK_CFG, 8'h02);
        axi_write(pao_pkg::OFF_CONTROL, 8'h80);
        mon_clear <= 1'b0;
        pulse(1, 4);
        expect_reg(pao_pkg::OFF_ACC_L, 8'h04);
        expect_reg(pao_pkg::OFF_ACC_U, 8'h00);
        check(partner.rise_count, 1);
        check(synth_output, 1'b1);
        expect_reg(pao_pkg::OFF_CONTROL, 8'hA0);
        expect_reg(pao_pkg::OFF_IRQ, 8'h01);
        check(pin_oe, 1'b1);
        check(pin_out, 1'b1);
        route <= 1'b0;
        @(posedge aclk);
        check(pin_oe, 1'b0);
        expect_reg(pao_pkg::OFF_IRQ, 8'h01);
        axi_write(pao_pkg::OFF_IRQ, 8'h00);
        expect_reg(pao_pkg::OFF_IRQ, 8'h00);
        $display("test fixed duty done");
        axi_write(pao_pkg::OFF_IRQ, 8'h02);
        axi_write(pao_pkg::OFF_CONTROL, 8'h90);
        // The registered output moves one edge after the control write lands.
        @(posedge aclk);
        check(synth_output, 1'b0);
        expect_reg(pao_pkg::OFF_IRQ, 8'h03);
        check(irq_request, 1'b0);
        axi_write(pao_pkg::OFF_IRQ, 8'h0F);
        check(irq_request, 1'b1);
        axi_write(pao_pkg::OFF_CONTROL, 8'h10);
        check(irq_request, 1'b0);
        axi_write(pao_pkg::OFF_IRQ, 8'h00);
        $display("test polarity done");
        axi_write(pao_pkg::OFF_ACC_L, 8'h00);
        set_inc(8'h00, 8'h00, 8'h05);
        axi_write(pao_pkg::OFF_CONTROL, 8'h80);
        pulse(1, 1);
        expect_reg(pao_pkg::OFF_ACC_L, 8'h05);
        set_inc(8'h00, 8'h00, 8'h10);
        pulse(1, 1);
        expect_reg(pao_pkg::OFF_ACC_L, 8'h0A);
        pulse(1, 1);
        axi_read(pao_pkg::OFF_ACC_L);
        r3 = rd[7:0];
        pulse(1, 1);
        axi_read(pao_pkg::OFF_ACC_L);
        check(8'(rd[7:0] - r3), 8'h10);
        expect_reg(pao_pkg::OFF_INC_L, 8'h10);
        $display("test double buffer done");
        axi_write(pao_pkg::OFF_CONTROL, 8'h00);
        axi_write(pao_pkg::OFF_ACC_L, 8'h00);
        set_inc(8'h04, 8'h00, 8'h00);
        axi_write(pao_pkg::OFF_CLK_CFG, 8'h22);
        axi_write(pao_pkg::OFF_CONTROL, 8'h81);
        mon_clear <= 1'b1;
        @(posedge aclk);
        mon_clear <= 1'b0;
        pulse(1, 11);
        check(partner.rise_count, 2);
        check(partner.high_cycles, 32);
        $display("test pulse mode done");
        print_verdict();
    end
endmodule
